/* design/byte_port_pkg.sv */
package byte_port_pkg;

   // clock rate and handshake timing
   localparam int unsigned CLK_MHZ          = 100;
   localparam int unsigned ACK_WIDTH_NS     = 4800;
   localparam int unsigned ACK_CYCLES       = (ACK_WIDTH_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned BUSY_MIN_NS      = 10000;
   localparam int unsigned BUSY_MIN_CYCLES  = (BUSY_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned INIT_NS          = 1000;
   localparam int unsigned INIT_CYCLES      = (INIT_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned CNT_W            = 16;

   // data byte layout: line 1 is bit 0, line 8 is bit 7
   localparam int unsigned DATA_W           = 8;
   localparam int unsigned DATA_LSB         = 0;
   localparam int unsigned DATA_MSB         = 7;

   // synchroniser depth and reset values
   localparam int unsigned SYNC_STAGES      = 3;
   localparam logic        SPARE_LEVEL      = 1'b0;
   localparam logic        BUSY_RESET       = 1'b1;
   localparam logic        ACK_IDLE         = 1'b1;
   localparam logic        SELECT_RESET     = 1'b0;

   typedef enum logic [4:0] {
      ST_INIT    = 5'h01,
      ST_OFFLINE = 5'h02,
      ST_READY   = 5'h04,
      ST_HOLD    = 5'h08,
      ST_ACK     = 5'h10
   } port_state_t;

   // pins from the host, synchronised and filtered
   typedef struct packed {
      logic              strobe_b;
      logic              init_b;
      logic [DATA_W-1:0] data;
   } host_pins_t;

   // pins toward the host
   typedef struct packed {
      logic busy;
      logic ack_b;
      logic select;
      logic fault_b;
      logic paper_error;
      logic spare_output_low;
   } status_pins_t;

   // received character toward the plotter core
   typedef struct packed {
      logic              valid;
      logic [DATA_W-1:0] data;
   } rx_char_t;

endpackage

/* design/parallel_byte_receiver_port.sv */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - busy rises after each valid strobe fall
// - busy low only when next character accepted
// - line one is lsb, line eight msb
// - low request pulse asks exactly one character
// - request pulse no later than busy falls
// - request pulse on every offline to online
// - host init low forces reinitialization, select stays high
// - select low at reset, high after init
// - fault low while any error exists
// - paper error high on paper out or fault
// - paper error high forces fault low
// - cable present selects this parallel path
// - point to point, no addressing logic
// - byte wide asynchronous, three handshake lines
// - strobe, ack, init, fault are active low
// - spare output always driven low
module parallel_byte_receiver_port
   import byte_port_pkg::*;
#(
   parameter int unsigned ACK_LEN   = ACK_CYCLES,
   parameter int unsigned BUSY_MIN  = BUSY_MIN_CYCLES,
   parameter int unsigned INIT_LEN  = INIT_CYCLES
) (
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst_b,
   // host pins
   input  wire logic              strobe_b,
   input  wire logic              init_b,
   input  wire logic [DATA_W-1:0] data_in,
   input  wire logic              cable_present,
   // plotter core side
   input  wire logic              core_ready,
   input  wire logic              online_req,
   input  wire logic              paper_out,
   input  wire logic              operator_fault,
   input  wire logic              internal_error,
   output logic                   rx_valid,
   output logic      [DATA_W-1:0] rx_data,
   output logic                   port_active,
   // pins toward host
   output logic                   busy,
   output logic                   ack_b,
   output logic                   select,
   output logic                   fault_b,
   output logic                   paper_error,
   output logic                   spare_output_low
);

   localparam int unsigned SYNC_W = DATA_W + 2;
   localparam logic [SYNC_W-1:0] SYNC_IDLE = {1'b1, 1'b1, {DATA_W{1'b0}}};

   typedef struct packed {
      port_state_t       state;
      logic [CNT_W-1:0]  cnt;
      logic              strobe_prev;
      rx_char_t          rx;
      status_pins_t      pins;
      logic              active;
   } port_regs_t;

   port_regs_t  r_q;
   port_regs_t  r_d;
   host_pins_t  host_s;
   logic [SYNC_W-1:0] sync_out;
   logic        strobe_fall;
   logic        error_now;
   logic        paper_now;
   logic        go_online;

   // strobe, init and data all pass the filtered synchroniser
   pin_sync #(
      .WIDTH (SYNC_W)
   ) u_sync (
      .core_clk   (core_clk),
      .rst_b      (rst_b),
      .pin_in     ({strobe_b, init_b, data_in} ^ SYNC_IDLE),
      .idle_level (SYNC_IDLE),
      .level_out  (sync_out)
   );

   assign host_s = sync_out;

   // falling edge of the filtered strobe; the host keeps data stable while it is low
   assign strobe_fall = r_q.strobe_prev & ~host_s.strobe_b;
   assign paper_now   = paper_out | operator_fault;
   assign error_now   = internal_error | paper_now;
   // cable attached means this path is used, with no address match anywhere
   assign go_online   = online_req & cable_present;

   always_comb begin
      r_d                       = r_q;
      r_d.strobe_prev           = host_s.strobe_b;
      r_d.rx.valid              = 1'b0;
      r_d.pins.spare_output_low = SPARE_LEVEL;
      r_d.pins.paper_error      = paper_now;
      r_d.pins.fault_b          = ~error_now;
      r_d.active                = cable_present;
      if (r_q.cnt != '0) begin
         r_d.cnt = r_q.cnt - 1'b1;
      end
      unique case (r_q.state)
         ST_INIT: begin
            r_d.pins.busy   = 1'b1;
            r_d.pins.ack_b  = ACK_IDLE;
            if (r_q.cnt == '0) begin
               r_d.pins.select = 1'b1;
               r_d.state       = ST_OFFLINE;
            end
         end
         ST_OFFLINE: begin
            r_d.pins.busy  = 1'b1;
            if (go_online) begin
               // every return to online issues one request
               r_d.pins.ack_b = 1'b0;
               r_d.cnt        = CNT_W'(ACK_LEN);
               r_d.state      = ST_ACK;
            end
         end
         ST_READY: begin
            if (!go_online) begin
               r_d.pins.busy = 1'b1;
               r_d.state     = ST_OFFLINE;
            end else if (strobe_fall) begin
               // one character per fall, line one into bit zero
               r_d.rx.data      = host_s.data;
               r_d.rx.valid     = 1'b1;
               r_d.pins.busy    = 1'b1;
               r_d.cnt          = CNT_W'(BUSY_MIN);
               r_d.state        = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (r_q.cnt == '0 && core_ready) begin
               if (!go_online) begin
                  r_d.state = ST_OFFLINE;
               end else begin
                  // request starts while busy still high
                  r_d.pins.ack_b = 1'b0;
                  r_d.cnt        = CNT_W'(ACK_LEN);
                  r_d.state      = ST_ACK;
               end
            end
         end
         ST_ACK: begin
            if (r_q.cnt == '0) begin
               // busy drops only with the request ended and core able to take more
               r_d.pins.ack_b = ACK_IDLE;
               r_d.pins.busy  = ~core_ready;
               if (core_ready) begin
                  r_d.state = ST_READY;
               end else begin
                  r_d.state = ST_HOLD;
               end
            end
         end
         default: begin
            r_d.state = ST_INIT;
            r_d.cnt   = CNT_W'(INIT_LEN);
         end
      endcase
      // host init wins over everything and restarts the port
      if (!host_s.init_b) begin
         r_d.state       = ST_INIT;
         r_d.cnt         = CNT_W'(INIT_LEN);
         r_d.pins.busy   = 1'b1;
         r_d.pins.ack_b  = ACK_IDLE;
         r_d.rx.valid    = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         r_q.state                 <= ST_INIT;
         r_q.cnt                   <= CNT_W'(INIT_LEN);
         r_q.strobe_prev           <= 1'b1;
         r_q.rx                    <= '0;
         r_q.pins.busy             <= BUSY_RESET;
         r_q.pins.ack_b            <= ACK_IDLE;
         r_q.pins.select           <= SELECT_RESET;
         r_q.pins.fault_b          <= 1'b1;
         r_q.pins.paper_error      <= 1'b0;
         r_q.pins.spare_output_low <= SPARE_LEVEL;
         r_q.active                <= 1'b0;
      end else begin
         r_q <= r_d;
      end
   end

   assign busy             = r_q.pins.busy;
   assign ack_b            = r_q.pins.ack_b;
   assign select           = r_q.pins.select;
   assign fault_b          = r_q.pins.fault_b;
   assign paper_error      = r_q.pins.paper_error;
   assign spare_output_low = r_q.pins.spare_output_low;
   assign rx_valid         = r_q.rx.valid;
   assign rx_data          = r_q.rx.data;
   assign port_active      = r_q.active;

endmodule

`default_nettype wire

/* design/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// three sync flops and one level flop per line; a change is taken once stages two and three agree
module pin_sync
   import byte_port_pkg::*;
#(
   parameter int unsigned WIDTH = 10
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst_b,
   // raw pins and idle level
   input  wire logic [WIDTH-1:0] pin_in,
   input  wire logic [WIDTH-1:0] idle_level,
   // filtered level
   output logic      [WIDTH-1:0] level_out
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] lvl;
   } sync_state_t;

   sync_state_t st_q;
   sync_state_t st_d;

   always_comb begin
      st_d    = st_q;
      st_d.s1 = pin_in;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (st_q.s2[i] == st_q.s3[i]) begin
            st_d.lvl[i] = st_q.s3[i];
         end
      end
   end

   // stages reset to zero, which the xor maps to each pin's idle level
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign level_out = st_q.lvl ^ idle_level;

endmodule

`default_nettype wire

/* test/byte_port_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module byte_port_chk
   import byte_port_pkg::*;
#(
   parameter int unsigned ACK_LEN  = ACK_CYCLES,
   parameter int unsigned BUSY_MIN = BUSY_MIN_CYCLES,
   parameter int unsigned INIT_LEN = INIT_CYCLES
) (
   // clock, reset and host pins
   input wire logic              core_clk, rst_b, strobe_b, init_b, cable_present,
   input wire logic [DATA_W-1:0] data_in,
   // core side
   input wire logic              core_ready, online_req, paper_out, operator_fault, internal_error,
   input wire logic              rx_valid, port_active,
   input wire logic [DATA_W-1:0] rx_data,
   // toward host
   input wire logic              busy, ack_b, select, fault_b, paper_error, spare_output_low
);
   logic [15:0] ack_n_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // length of the current request pulse
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) ack_n_q <= 16'h0000;
      else ack_n_q <= ack_b ? 16'h0000 : ack_n_q + 16'h0001;
   end
   property p_spare; spare_output_low == 1'b0; endproperty
   a_spare: assert property (p_spare) else $error("spare output high");
   property p_pe_flt; paper_error |-> !fault_b; endproperty
   a_pe_flt: assert property (p_pe_flt) else $error("paper error without fault");
   property p_paper; $past(rst_b) |-> paper_error == ($past(paper_out) | $past(operator_fault)); endproperty
   a_paper: assert property (p_paper) else $error("paper error wrong");
   property p_fault;
      $past(rst_b) |-> fault_b == !($past(paper_out) | $past(operator_fault) | $past(internal_error));
   endproperty
   a_fault: assert property (p_fault) else $error("fault level wrong");
   property p_sel; $past(select) |-> select; endproperty
   a_sel: assert property (p_sel) else $error("select dropped");
   property p_take; rx_valid |-> (busy && !$past(busy)) ##1 !rx_valid; endproperty
   a_take: assert property (p_take) else $error("byte taken while busy");
   property p_hold; !rx_valid |-> $stable(rx_data); endproperty
   a_hold: assert property (p_hold) else $error("rx data moved");
   // pulse spans the load cycle plus the ACK_LEN countdown
   property p_ack_len; $rose(ack_b) |-> ack_n_q == 16'(ACK_LEN + 1); endproperty
   a_ack_len: assert property (p_ack_len) else $error("request pulse length");
   property p_ack_first; $fell(busy) |-> $past(ack_b) == 1'b0; endproperty
   a_ack_first: assert property (p_ack_first) else $error("busy fell without request");
endmodule
bind parallel_byte_receiver_port byte_port_chk #(.ACK_LEN(ACK_LEN), .BUSY_MIN(BUSY_MIN), .INIT_LEN(INIT_LEN)) CHK_I (
   .core_clk, .rst_b, .strobe_b, .init_b, .cable_present, .data_in, .core_ready, .online_req,
   .paper_out, .operator_fault, .internal_error, .rx_valid, .port_active, .rx_data,
   .busy, .ack_b, .select, .fault_b, .paper_error, .spare_output_low);
`default_nettype wire

/* test/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// setup, strobe width and hold are each 0.5 us
module host_model
   import byte_port_pkg::*;
#(
   parameter int unsigned GAP = 50
) (
   // clock and bench command
   input  wire logic              core_clk,
   input  wire logic              go,
   input  wire logic [DATA_W-1:0] byte_in,
   // pins toward the port
   output logic                   strobe_b,
   output logic      [DATA_W-1:0] data_in,
   output logic                   done
);
   initial begin
      {strobe_b, data_in, done} = {1'b1, 8'h00, 1'b0};
      forever begin
         @(posedge core_clk iff go);
         @(negedge core_clk);
         data_in = byte_in;
         repeat (GAP) @(negedge core_clk);
         strobe_b = 1'b0;
         repeat (GAP) @(negedge core_clk);
         strobe_b = 1'b1;
         repeat (GAP) @(negedge core_clk);
         // released lines must not keep the old byte
         data_in = ~byte_in;
         done = 1'b1;
         @(posedge core_clk iff !go);
         @(negedge core_clk);
         done = 1'b0;
      end
   end
endmodule
`default_nettype wire

/* test/parallel_byte_receiver_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module parallel_byte_receiver_port_test;
   import byte_port_pkg::*;
   logic              core_clk, rst_b, init_b, cable_present, core_ready, online_req, go, done, ack_q;
   logic              paper_out, operator_fault, internal_error, strobe_b, rx_valid, port_active;
   logic              busy, ack_b, select, fault_b, paper_error, spare_output_low;
   logic [DATA_W-1:0] byte_in, data_in, rx_data, b, exp_b;
   logic [DATA_W-1:0] exp_q[$];
   int                n_fail, checks, n_ack, exp_ack, i;
   parallel_byte_receiver_port #(.ACK_LEN(4), .BUSY_MIN(8), .INIT_LEN(4)) DUT (
      .core_clk, .rst_b, .strobe_b, .init_b, .data_in, .cable_present, .core_ready, .online_req,
      .paper_out, .operator_fault, .internal_error, .rx_valid, .rx_data, .port_active,
      .busy, .ack_b, .select, .fault_b, .paper_error, .spare_output_low);
   host_model HOST (.core_clk, .go, .byte_in, .strobe_b, .data_in, .done);
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      ack_q <= ack_b;
      if (ack_q === 1'b1 && ack_b === 1'b0) n_ack++;
      if (rx_valid === 1'b1) begin
         // pop once, so a mismatch report does not eat the next byte
         exp_b = exp_q.size() ? exp_q.pop_front() : 8'hxx;
         `CHK("rx_data", exp_b, rx_data)
      end
   end
   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic give_verdict;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic wait_idle;
      int k;
      for (k = 0; k < 5000 && busy !== 1'b0; k++) @(negedge core_clk);
      `CHK("busy_wait", 1'b0, busy)
      if (busy !== 1'b0) give_verdict;
   endtask
   task automatic send(input logic [DATA_W-1:0] v, input bit take);
      int k;
      byte_in = v;
      // queued before the strobe: the port hands the byte on long before done
      if (take) exp_q.push_back(v);
      go = 1'b1;
      for (k = 0; k < 400 && done !== 1'b1; k++) @(posedge core_clk);
      `CHK("host_done", 1'b1, done)
      @(negedge core_clk);
      go = 1'b0;
      tick(2);
      if (take) exp_ack++;
   endtask
   initial begin
      {rst_b, init_b, cable_present, core_ready, online_req, go} = 6'h14;
      {paper_out, operator_fault, internal_error} = 3'h0;
      byte_in = 8'h00;
      i = $urandom(63);
      tick(16);
      `CHK("select_rst", 1'b0, select)
      rst_b = 1'b1;
      tick(12);
      `CHK("select_up", 1'b1, select)
      `CHK("busy_offline", 1'b1, busy)
      {cable_present, online_req} = 2'h3;
      exp_ack = 1;
      wait_idle;
      // stalled core: the second strobe lands while busy
      core_ready = 1'b0;
      send(8'ha5, 1'b1);
      send(8'h5a, 1'b0);
      core_ready = 1'b1;
      wait_idle;
      for (i = 0; i < 10; i++) begin
         b = (i == 0) ? 8'h01 : (i == 1) ? 8'h80 : 8'($urandom);
         core_ready = 1'b0;
         send(b, 1'b1);
         tick($urandom % 20);
         core_ready = 1'b1;
         wait_idle;
      end
      for (i = 0; i < 8; i++) begin
         {paper_out, operator_fault, internal_error} = 3'(i);
         tick(2);
         `CHK("fault_b", ~|3'(i), fault_b)
         `CHK("paper_error", 3'(i) > 3'h1, paper_error)
      end
      {paper_out, operator_fault, internal_error} = 3'h0;
      init_b = 1'b0;
      tick(10);
      `CHK("busy_init", 1'b1, busy)
      init_b = 1'b1;
      exp_ack++;
      wait_idle;
      `CHK("select_kept", 1'b1, select)
      online_req = 1'b0;
      tick(4);
      `CHK("busy_off", 1'b1, busy)
      send(8'h3c, 1'b0);
      online_req = 1'b1;
      exp_ack++;
      wait_idle;
      cable_present = 1'b0;
      tick(2);
      `CHK("port_active", 1'b0, port_active)
      cable_present = 1'b1;
      exp_ack++;
      wait_idle;
      `CHK("port_active_on", 1'b1, port_active)
      send(8'hc3, 1'b1);
      wait_idle;
      `CHK("ack_count", exp_ack, n_ack)
      `CHK("rx_left", 0, exp_q.size())
      `CHK("spare", 1'b0, spare_output_low)
      give_verdict;
   end
   initial begin
      repeat (90000) @(posedge core_clk);
      `CHK("timeout", 1'b1, 1'b0)
      give_verdict;
   end
endmodule
`default_nettype wire
